// file: ocm_map.svh
// Named constants for the output macrocell configuration block
`ifndef OCM_MAP_SVH
`define OCM_MAP_SVH
`define OCM_NCELL 8
`define OCM_NPT 8
`define OCM_RST_SYNC 1'b1
`define OCM_RST_MODE0 1'b0
`define OCM_RST_POL 8'h00
`define OCM_RST_IO 8'h00
`define OCM_RST_PINS 8'h00
`define OCM_CELL_OUT_A 0
`define OCM_CELL_IN_A 3
`define OCM_CELL_IN_B 4
`define OCM_CELL_OUT_B 7
`define OCM_PT_OE 0
`endif

// file: ocm_pkg.sv
// Types for the output macrocell configuration block
package ocm_pkg;
    // Gray order along simple, complex, registered
    typedef enum logic [1:0] {
        OCM_SIMPLE = 2'b00,
        OCM_COMPLEX = 2'b01,
        OCM_REGISTERED = 2'b11,
        OCM_ILLEGAL = 2'b10
    } ocm_mode_t;

    typedef struct packed {
        logic [7:0] q;
    } ocm_bank_t;

    typedef struct packed {
        logic sync_select_bit;
        logic mode_config_bit_zero;
        logic [7:0] pol;
        logic [7:0] io_config_bit;
        logic clk_prev;
        ocm_mode_t mode;
        logic [7:0] pin;
        logic [7:0] pin_oe;
        logic [7:0] fb;
        logic [7:0] fb_valid;
    } ocm_state_t;
endpackage

// file: ocm_reg_if.sv
// Carrier between the control logic and the macrocell register bank
`timescale 1ns/1ps
interface ocm_reg_if #(parameter int N = 8);
    logic [N-1:0] d;
    logic [N-1:0] en;
    logic preload;
    logic [N-1:0] preload_data;
    logic [N-1:0] q;
    modport ctl (output d, output en, output preload,
        output preload_data, input q);
    modport bank (input d, input en, input preload,
        input preload_data, output q);
endinterface

// file: ocm_reg_bank.sv
// Macrocell register bank with clear and preload
`timescale 1ns/1ps
`include "ocm_map.svh"
module ocm_reg_bank (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control side
    ocm_reg_if.bank rif
);
    import ocm_pkg::*;

    ocm_bank_t state_q;
    ocm_bank_t next_state;

    always_comb begin
        next_state = state_q;
        // Preload wins so a test pattern always lands whole
        if (rif.preload) begin
            next_state.q = rif.preload_data;
        end else begin
            for (int i = 0; i < `OCM_NCELL; i++) begin
                if (rif.en[i]) begin
                    next_state.q[i] = rif.d[i];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_q.q <= `OCM_RST_PINS;
        end else begin
            state_q <= next_state;
        end
    end

    assign rif.q = state_q.q;

    a_preload_lands: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        rif.preload |=> rif.q == $past(rif.preload_data))
        else $error("preload value not held in registers");
    c_preload_seen: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        rif.preload ##1 !rif.preload);
endmodule

// file: ocm_top.sv
// Output macrocell configuration and pin routing
`timescale 1ns/1ps
`include "ocm_map.svh"
// Operation
// - One global mode: simple, complex, registered
// - Two global bits pick mode for all
// - Per-cell polarity bit inverts output always
// - Per-cell bit selects output or I/O in registered mode, output or input in simple mode
// - Configuration is two global plus sixteen bits
// - Eight macrocells, each drives one pin
// - Registered: pins are clock and enable only
// - Registered: clock, enable pins carry no data
// - Complex: dedicated pins feed via outer paths
// - Complex: outer cells lose pin feedback
// - Simple: feedback goes via neighbour path
// - Simple: inner cells outputs, no feedback
// - Registers capture only in registered mode
// - Complex supports product-term enabled outputs
// - Simple outputs have no enable control
// - Registers cleared at reset, preloadable
// - Registered cells share clock and enable
// - Registered eight terms, I/O seven terms
// - Complex reserves one term as enable
module ocm_top (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_B,
    // Architecture configuration
    input wire logic I_CFG_LOAD,
    input wire logic I_SYNC_SELECT_BIT,
    input wire logic I_MODE_CONFIG_BIT_ZERO,
    input wire logic [7:0] I_POLARITY,
    input wire logic [7:0] I_IO_CONFIG_BIT,
    // Dedicated pins and array terms
    input wire logic I_DED_CLK,
    input wire logic I_DED_OE_B,
    input wire logic [63:0] I_PT,
    input wire logic [7:0] I_PIN_IN,
    // Test preload
    input wire logic I_PRELOAD,
    input wire logic [7:0] I_PRELOAD_DATA,
    // Pins, feedback and status
    output logic [7:0] O_PIN,
    output logic [7:0] O_PIN_OE,
    output logic [7:0] O_FB,
    output logic [7:0] O_FB_VALID,
    output logic [1:0] O_MODE,
    output logic [7:0] O_REG_Q
);
    import ocm_pkg::*;

    ocm_state_t state_q;
    ocm_state_t next_state;
    ocm_reg_if #(.N(`OCM_NCELL)) rif ();

    function automatic ocm_mode_t mode_of(input logic syn, input logic ac0);
        ocm_mode_t m;
        m = OCM_ILLEGAL;
        unique case ({syn, ac0})
            2'b10: m = OCM_SIMPLE;
            2'b11: m = OCM_COMPLEX;
            2'b01: m = OCM_REGISTERED;
            2'b00: m = OCM_ILLEGAL;
        endcase
        return m;
    endfunction

    // Sum of a cell's terms, optionally leaving out the enable term
    function automatic logic sum_of(input logic [7:0] t, input logic skip);
        logic s;
        s = 1'b0;
        for (int k = 0; k < `OCM_NPT; k++) begin
            if (!(skip && k == `OCM_PT_OE)) begin
                s = s | t[k];
            end
        end
        return s;
    endfunction

    ocm_reg_bank u_bank (
        .i_clk(I_REF_CLK),
        .i_rst_b(I_RST_B),
        .rif(rif)
    );

    ocm_mode_t cur_mode;
    logic clk_rise;
    logic [7:0] cell_pt [`OCM_NCELL];
    logic [7:0] reg_d;
    logic [7:0] reg_en;

    assign cur_mode = mode_of(state_q.sync_select_bit,
        state_q.mode_config_bit_zero);
    // Pin is taken as synchronous; an edge is seen at the first reference clock edge after it rises
    assign clk_rise = I_DED_CLK & ~state_q.clk_prev;

    genvar g;
    generate
        for (g = 0; g < `OCM_NCELL; g++) begin : g_cell
            assign cell_pt[g] = I_PT[g*`OCM_NPT +: `OCM_NPT];
            assign reg_d[g] = sum_of(cell_pt[g], 1'b0);
            // Shared clock only; I/O cells never tick
            assign reg_en[g] = clk_rise && cur_mode == OCM_REGISTERED
                && !state_q.io_config_bit[g];
        end
    endgenerate

    assign rif.d = reg_d;
    assign rif.en = reg_en;
    assign rif.preload = I_PRELOAD;
    assign rif.preload_data = I_PRELOAD_DATA;

    always_comb begin
        next_state = state_q;
        next_state.clk_prev = I_DED_CLK;
        next_state.mode = cur_mode;
        if (I_CFG_LOAD) begin
            next_state.sync_select_bit = I_SYNC_SELECT_BIT;
            next_state.mode_config_bit_zero = I_MODE_CONFIG_BIT_ZERO;
            next_state.pol = I_POLARITY;
            next_state.io_config_bit = I_IO_CONFIG_BIT;
        end
        for (int i = 0; i < `OCM_NCELL; i++) begin
            next_state.pin[i] = 1'b0;
            next_state.pin_oe[i] = 1'b0;
            next_state.fb[i] = 1'b0;
            next_state.fb_valid[i] = 1'b0;
            unique case (cur_mode)
                OCM_REGISTERED: begin
                    if (!state_q.io_config_bit[i]) begin
                        next_state.pin[i] = rif.q[i] ^ state_q.pol[i];
                        next_state.pin_oe[i] = !I_DED_OE_B;
                        next_state.fb[i] = rif.q[i];
                    end else begin
                        next_state.pin[i] = sum_of(cell_pt[i], 1'b1)
                            ^ state_q.pol[i];
                        next_state.pin_oe[i] = cell_pt[i][`OCM_PT_OE];
                        next_state.fb[i] = I_PIN_IN[i];
                    end
                    // Dedicated pins never reach the array here
                    next_state.fb_valid[i] = 1'b1;
                end
                OCM_COMPLEX: begin
                    next_state.pin[i] = sum_of(cell_pt[i], 1'b1)
                        ^ state_q.pol[i];
                    next_state.pin_oe[i] = cell_pt[i][`OCM_PT_OE];
                    next_state.fb[i] = I_PIN_IN[i];
                    next_state.fb_valid[i] = 1'b1;
                end
                OCM_SIMPLE: begin
                    next_state.pin[i] = sum_of(cell_pt[i], 1'b0)
                        ^ state_q.pol[i];
                    // No enable term; io bit just turns the cell to input
                    next_state.pin_oe[i] = !state_q.io_config_bit[i];
                    next_state.fb_valid[i] = 1'b1;
                    if (i < `OCM_CELL_IN_B) begin
                        next_state.fb[i] = (i == `OCM_CELL_OUT_A) ? I_DED_CLK
                            : I_PIN_IN[i-1];
                    end else begin
                        next_state.fb[i] = (i == `OCM_CELL_OUT_B) ? I_DED_OE_B
                            : I_PIN_IN[i+1];
                    end
                end
                default: begin
                    // Undefined code: pins float, nothing fed back
                end
            endcase
        end
        if (cur_mode == OCM_COMPLEX) begin
            next_state.fb[`OCM_CELL_OUT_A] = I_DED_CLK;
            next_state.fb[`OCM_CELL_OUT_B] = I_DED_OE_B;
        end
        if (cur_mode == OCM_SIMPLE) begin
            next_state.pin_oe[`OCM_CELL_IN_A] = 1'b1;
            next_state.pin_oe[`OCM_CELL_IN_B] = 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            state_q.sync_select_bit <= `OCM_RST_SYNC;
            state_q.mode_config_bit_zero <= `OCM_RST_MODE0;
            state_q.pol <= `OCM_RST_POL;
            state_q.io_config_bit <= `OCM_RST_IO;
            state_q.clk_prev <= 1'b0;
            state_q.mode <= OCM_SIMPLE;
            state_q.pin <= `OCM_RST_PINS;
            state_q.pin_oe <= `OCM_RST_PINS;
            state_q.fb <= `OCM_RST_PINS;
            state_q.fb_valid <= `OCM_RST_PINS;
        end else begin
            state_q <= next_state;
        end
    end

    assign O_PIN = state_q.pin;
    assign O_PIN_OE = state_q.pin_oe;
    assign O_FB = state_q.fb;
    assign O_FB_VALID = state_q.fb_valid;
    assign O_MODE = state_q.mode;
    assign O_REG_Q = rif.q;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);

    a_cfg_load_takes: assert property (I_CFG_LOAD |=>
        state_q.io_config_bit == $past(I_IO_CONFIG_BIT)
        && state_q.pol == $past(I_POLARITY)
        && cur_mode == mode_of($past(I_SYNC_SELECT_BIT),
            $past(I_MODE_CONFIG_BIT_ZERO)))
        else $error("configuration load not taken");
    // Outputs keep reset values one edge past release, not mode values
    a_simple_inner_out: assert property ($past(I_RST_B)
        && O_MODE == OCM_SIMPLE |->
        O_PIN_OE[`OCM_CELL_IN_A] && O_PIN_OE[`OCM_CELL_IN_B])
        else $error("inner cells not driven in simple mode");
    a_simple_neighbour: assert property ($past(I_RST_B)
        && O_MODE == OCM_SIMPLE |->
        O_FB[1] == $past(I_PIN_IN[0]) && O_FB[5] == $past(I_PIN_IN[6]))
        else $error("simple feedback not from neighbour");
    a_complex_ded_fb: assert property (O_MODE == OCM_COMPLEX |->
        O_FB[`OCM_CELL_OUT_A] == $past(I_DED_CLK)
        && O_FB[`OCM_CELL_OUT_B] == $past(I_DED_OE_B))
        else $error("dedicated inputs not on outer paths");
    a_complex_pt_oe: assert property (O_MODE == OCM_COMPLEX |->
        O_PIN_OE[2] == $past(I_PT[2*`OCM_NPT + `OCM_PT_OE]))
        else $error("complex enable not from its term");
    a_reg_shared_oe: assert property (O_MODE == OCM_REGISTERED |->
        (O_PIN_OE & ~$past(state_q.io_config_bit))
        == ({`OCM_NCELL{!$past(I_DED_OE_B)}}
        & ~$past(state_q.io_config_bit)))
        else $error("registered enable not shared low-active");
    a_reg_capture: assert property (cur_mode == OCM_REGISTERED
        && I_DED_CLK && !state_q.clk_prev && !I_PRELOAD
        && !state_q.io_config_bit[`OCM_CELL_IN_B] |=>
        O_REG_Q[`OCM_CELL_IN_B] == $past(|cell_pt[`OCM_CELL_IN_B]))
        else $error("register missed shared clock edge");
    a_reg_feedback: assert property (O_MODE == OCM_REGISTERED |->
        (O_FB & ~$past(state_q.io_config_bit))
        == ($past(rif.q) & ~$past(state_q.io_config_bit)))
        else $error("registered feedback not from register");
    a_polarity: assert property ($past(I_RST_B)
        && O_MODE == OCM_SIMPLE |->
        O_PIN[5] == ($past(|cell_pt[5]) ^ $past(state_q.pol[5])))
        else $error("polarity not applied");
    a_no_tick_off_mode: assert property (cur_mode != OCM_REGISTERED
        && !I_PRELOAD |=> O_REG_Q == $past(O_REG_Q))
        else $error("register changed outside registered mode");

    c_complex_mode: cover property (O_MODE == OCM_COMPLEX);
    c_reg_tick: cover property (reg_en[`OCM_CELL_IN_B]
        ##1 O_MODE == OCM_REGISTERED);
    c_simple_to_reg: cover property (O_MODE == OCM_SIMPLE
        ##[1:20] O_MODE == OCM_REGISTERED);
endmodule

// file: ocm_board.sv
// Board model that closes the loop from the pins back to their inputs
`timescale 1ns/1ps
module ocm_board (
    // Device pins
    input wire logic [7:0] i_pin,
    input wire logic [7:0] i_pin_oe,
    // Board level per pin, all ones models the pull-ups alone
    input wire logic [7:0] i_board,
    // Level seen back at each pin
    output logic [7:0] o_pin_in
);
    // Driven pin reads its own level; released pin shows the board
    assign o_pin_in = (i_pin & i_pin_oe) | (i_board & ~i_pin_oe);
endmodule

// file: ocm_top_tb_top.sv
// Self-checking bench for the output macrocell configuration block
`timescale 1ns/1ps
module ocm_top_tb_top;
    import ocm_pkg::*;
    logic clk = 0, rst_b = 0, cfg_load = 0, sync = 1, mode0 = 0;
    logic dclk = 0, doe_b = 1, preload = 0;
    logic [7:0] pol = 8'h00, io = 8'h00, board = 8'hff, pin_in;
    logic [7:0] pre_data = 8'h00, q_exp = 8'h00;
    logic [63:0] pt = 64'h0000_0000_0000_0000;
    logic [7:0] o_pin, o_oe, o_fb, o_fbv, o_q;
    logic [1:0] o_mode;
    logic [1:0] codes [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    ocm_mode_t modes [4] = '{OCM_SIMPLE, OCM_COMPLEX, OCM_REGISTERED,
        OCM_ILLEGAL};
    int n_fail = 0, compares = 0, cyc = 0, k;

    ocm_top dut_u (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_CFG_LOAD(cfg_load),
        .I_SYNC_SELECT_BIT(sync), .I_MODE_CONFIG_BIT_ZERO(mode0),
        .I_POLARITY(pol), .I_IO_CONFIG_BIT(io), .I_DED_CLK(dclk),
        .I_DED_OE_B(doe_b), .I_PT(pt), .I_PIN_IN(pin_in),
        .I_PRELOAD(preload), .I_PRELOAD_DATA(pre_data), .O_PIN(o_pin),
        .O_PIN_OE(o_oe), .O_FB(o_fb), .O_FB_VALID(o_fbv), .O_MODE(o_mode),
        .O_REG_Q(o_q));
    ocm_board board_u (.i_pin(o_pin), .i_pin_oe(o_oe), .i_board(board),
        .o_pin_in(pin_in));

    initial begin
        forever #10 clk = ~clk;
    end

    // Whole run needs well under a few hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cfg(input logic s, m, input logic [7:0] p, i);
        {sync, mode0, pol, io} = {s, m, p, i};
        cfg_load = 1;
        step(1);
        cfg_load = 0;
        step(3);
    endtask

    // Expected pins, enables and feedback for one mode
    task automatic check_all(input ocm_mode_t md);
        logic [7:0] ep, eo, ef;
        int i;
        for (i = 0; i < 8; i++) begin
            ep[i] = (md == OCM_SIMPLE ? |pt[8*i+:8] : |pt[8*i+1+:7]) ^ pol[i];
            eo[i] = pt[8*i];
            ef[i] = pin_in[i];
            if (md == OCM_SIMPLE) eo[i] = !io[i] || i == 3 || i == 4;
            if (md == OCM_REGISTERED && !io[i]) begin
                ep[i] = q_exp[i] ^ pol[i];
                eo[i] = !doe_b;
                ef[i] = q_exp[i];
            end
        end
        if (md == OCM_SIMPLE) ef = {doe_b, pin_in[7:5], pin_in[2:0], dclk};
        if (md == OCM_COMPLEX) ef = {doe_b, pin_in[6:1], dclk};
        if (md == OCM_ILLEGAL) begin
            eo = 8'h00;
            ef = 8'h00;
        end
        chk("mode", {6'h00, md}, {6'h00, o_mode});
        chk("pin_oe", eo, o_oe);
        chk("pin", ep & eo, o_pin & eo);
        chk("fb", ef, o_fb);
        chk("fb_valid", md == OCM_ILLEGAL ? 8'h00 : 8'hff, o_fbv);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        step(20);
        chk("reset mode", 8'h00, {6'h00, o_mode});
        chk("reset reg_q", 8'h00, o_q);
        chk("reset pin_oe", 8'h00, o_oe);
        rst_b = 1;
        pt = 64'h0300_ff40_0001_2000;
        step(2);
        // Both read-back levels and enable pin level per mode
        for (k = 0; k < 4; k++) begin
            cfg(codes[k][1], codes[k][0], 8'h3c, 8'h0f);
            check_all(modes[k]);
            board = 8'h5a;
            doe_b = 0;
            step(3);
            check_all(modes[k]);
            board = 8'hff;
            doe_b = 1;
        end
        $display("test done: mode table");
        // Preload in simple mode, then clock pin must not capture
        cfg(1'b1, 1'b0, 8'h3c, 8'h0f);
        pre_data = 8'h5a;
        preload = 1;
        step(1);
        preload = 0;
        q_exp = 8'h5a;
        dclk = 1;
        step(2);
        dclk = 0;
        step(2);
        chk("reg_q simple", q_exp, o_q);
        // Registered mode capture on rising clock pin
        cfg(1'b0, 1'b1, 8'h3c, 8'h0f);
        check_all(OCM_REGISTERED);
        for (k = 0; k < 8; k++) q_exp[k] = io[k] ? q_exp[k] : |pt[8*k+:8];
        dclk = 1;
        step(2);
        dclk = 0;
        // Enable the registered pins so their values are compared
        doe_b = 0;
        step(3);
        chk("reg_q capture", q_exp, o_q);
        check_all(OCM_REGISTERED);
        // Preload wins over a clock edge in the same cycle
        pt = 64'h0000_0000_0000_0000;
        pre_data = 8'h33;
        preload = 1;
        dclk = 1;
        step(1);
        preload = 0;
        q_exp = 8'h33;
        step(2);
        dclk = 0;
        step(3);
        chk("reg_q preload", q_exp, o_q);
        check_all(OCM_REGISTERED);
        $display("test done: registers");
        finish_test();
    end
endmodule
